// ---- rtl/gauge_bank_regs.svh ----
// command codes, subcommands, reset values and timing of the standard command bank
`ifndef GAUGE_BANK_REGS_SVH
`define GAUGE_BANK_REGS_SVH
`define CMD_CONTROL_SUBCOMMAND_PORT 8'h00
`define CMD_HYPOTHETICAL_LOAD_CURRENT 8'h02
`define CMD_HYPOTHETICAL_LOAD_TIME_LEFT 8'h04
`define CMD_PACK_TEMPERATURE 8'h06
`define CMD_CELL_MILLIVOLTS 8'h08
`define CMD_STATUS_BITS 8'h0a
`define CMD_UNCOMPENSATED_REMAINING_MAH 8'h0c
`define CMD_UNCOMPENSATED_FULL_MAH 8'h0e
`define CMD_COMPENSATED_REMAINING_MAH 8'h10
`define CMD_COMPENSATED_FULL_MAH 8'h12
`define CMD_MEAN_CURRENT_MA 8'h14
`define CMD_RUNTIME_LEFT_MINUTES 8'h16
`define CMD_RAW_REMAINING_MAH 8'h18
`define CMD_IDLE_CURRENT_MA 8'h1a
`define CMD_SMOOTHED_REMAINING_MAH 8'h1c
`define CMD_PROGRAMMED_CHARGE_MA 8'h1e
`define CMD_PROGRAMMED_CHARGE_MV 8'h20
`define CMD_RAW_FULL_MAH 8'h22
`define CMD_MEAN_POWER_MW 8'h24
`define CMD_SMOOTHED_FULL_MAH 8'h26
`define CMD_BATTERY_HEALTH_PCT 8'h28
`define CMD_CHARGE_CYCLES_TOTAL 8'h2a
`define CMD_CHARGE_LEVEL_PCT 8'h2c
`define CMD_UNSMOOTHED_CHARGE_PCT 8'h2e
`define CMD_PRESENT_CURRENT_MA 8'h30
`define CMD_DIE_TEMPERATURE 8'h32
`define CMD_CHARGE_STAGE_CODE 8'h34
`define CMD_STAGE_TAPER_MA 8'h6e
`define CMD_COMPUTED_CHARGE_MA 8'h70
`define CMD_COMPUTED_CHARGE_VOLTS 8'h72
`define CMD_FLASH_SELECT 8'h3e
`define CMD_FLASH_DATA 8'h40
`define SUB_ENTER_LOCKED 16'h0020
`define SUB_SET_HIBERNATE 16'h0011
`define SUB_CLEAR_HIBERNATE 16'h0012
`define SUB_SET_SNOOZE 16'h0013
`define SUB_CLEAR_SNOOZE 16'h0014
`define SUB_HALF_CURRENT_ON 16'h0017
`define SUB_CHARGER_ON 16'h001a
`define SUB_CHARGER_OFF 16'h001b
`define SUB_HALF_CURRENT_OFF 16'h001e
`define REG_RESET 16'h0000
`define LOCKED_AT_RESET 1'b0
`define REG_WORDS_MIN 58
`define CLOCK_MHZ 100
`define SOC_PULSE_NS 1000
`endif

// ---- rtl/gauge_bank_pkg.sv ----
// types shared by the standard command bank
package gauge_bank_pkg;
  typedef enum logic [2:0] {
    pm_normal, pm_sleep, pm_deep_snooze, pm_hibernate, pack_presence_check_mode
  } power_mode_t;
  typedef enum logic [3:0] {
    ls_idle, ls_addr, ls_addr_chk, ls_ack_addr, ls_fetch, ls_rbyte, ls_rack, ls_wbyte, ls_wchk, ls_wack
  } link_state_t;
  typedef struct packed {
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    link_state_t st;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic [7:0] pointer;
    logic first;
    logic rw;
    logic oe;
    logic sda_o;
    logic req_tgl;
    logic ack_m, ack_s;
    logic req_we;
    logic [7:0] req_code;
    logic [7:0] req_data;
  } link_regs_t;
  typedef struct packed {
    logic req_m, req_s, req_d;
    logic ack_tgl;
    logic [7:0] rdata;
    logic [7:0] low_pending;
    logic locked;
    logic hib_req;
    logic snooze_req;
    logic div_half;
    logic chg_en;
    power_mode_t mode;
    logic [15:0] flash_sel;
    logic [15:0] soc_prev;
    logic [7:0] soc_cnt;
    logic soc_int;
    logic [15:0] chg_ma;
    logic [15:0] chg_mv;
  } bank_regs_t;
endpackage

// ---- rtl/gauge_standard_command_bank.sv ----
// standard command register bank with its serial slave engine
`timescale 1ns/10ps
`include "gauge_bank_regs.svh"
// Operation
// RL1: battery quantities are two-byte values
// RL2: value at even code, then odd code
// RL3: host sets code, then moves data
// RL4: host writes single bytes above 100 kHz
// RL5: all other transfers work at 400 kHz
// RL6: commands reach registers and flash data
// RL7: flash location from subclass and offset
// RL8: flash access refused in locked mode
// RL9: time-left register read-only when locked
// RL10: pack temperature writable in both modes
// RL11: measurements read-only locked, writable open
// RL12: stage and charge registers always read-only
// RL13: drive charge-level interrupt to host
// RL14: autonomous power modes plus host requests
// RL15: control charger without host involvement; charger_enable stays off until the host sends SUB_CHARGER_ON
// RL16: host commands arrive over serial slave
// RL17: control port takes two-byte subcommand
// RL18: lock subcommand, refused when already locked
// RL19: low byte even code, high byte odd
// RL20: refused or unlisted writes change nothing
module gauge_standard_command_bank
  import gauge_bank_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h55, // arbitrary
  parameter int REG_WORDS = 58
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clock,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic gauge_wr,
  input wire logic [5:0] gauge_index,
  input wire logic [15:0] gauge_value,
  input wire logic load_idle,
  input wire logic pack_present,
  input wire logic multi_step_charging,
  output logic locked_access_mode,
  output power_mode_t power_mode,
  output logic charger_enable,
  output logic [15:0] charger_ma,
  output logic [15:0] charger_mv,
  output logic charge_level_int
);
  // pulse length of the charge-level interrupt, rounded up
  localparam int SOC_PULSE_CYCLES = (`SOC_PULSE_NS * `CLOCK_MHZ + 999) / 1000;
  localparam logic [5:0] SOC_IDX = 6'(`CMD_CHARGE_LEVEL_PCT >> 1);
  localparam logic [5:0] PROG_MA_IDX = 6'(`CMD_PROGRAMMED_CHARGE_MA >> 1);
  localparam logic [5:0] PROG_MV_IDX = 6'(`CMD_PROGRAMMED_CHARGE_MV >> 1);
  localparam logic [5:0] CALC_MA_IDX = 6'(`CMD_COMPUTED_CHARGE_MA >> 1);
  localparam logic [5:0] CALC_MV_IDX = 6'(`CMD_COMPUTED_CHARGE_VOLTS >> 1);
  localparam logic [5:0] STAGE_IDX = 6'(`CMD_CHARGE_STAGE_CODE >> 1);

  // refuse a word store too small for the highest code pair
  if (REG_WORDS < `REG_WORDS_MIN) begin : bad_words
    $error("REG_WORDS too small for the command map");
  end

  link_regs_t l; // link-side state
  link_regs_t next_l;
  bank_regs_t b; // bank-side state
  bank_regs_t next_b;
  logic [15:0] reg_mem [0:REG_WORDS-1]; // one word per code pair
  logic [7:0] flash_mem [0:255]; // parameter store, no reset
  logic mem_we;
  logic [5:0] mem_idx;
  logic [15:0] mem_wdata;
  logic flash_we;
  logic [7:0] flash_loc;
  logic bank_evt;
  logic [7:0] pair_code;
  logic [15:0] pair_val;
  logic [15:0] rd_word;
  logic rise;
  logic fall;

  // listed code pairs: the contiguous block and the charge block
  function automatic logic pair_listed(input logic [7:0] even);
    return (even <= `CMD_CHARGE_STAGE_CODE) ||
      (even >= `CMD_STAGE_TAPER_MA && even <= `CMD_COMPUTED_CHARGE_VOLTS);
  endfunction

  // write right of a pair in the present access mode
  function automatic logic pair_writable(input logic [7:0] even, input logic lk);
    logic w;
    w = !lk; // RL9 RL11
    if (even == `CMD_CONTROL_SUBCOMMAND_PORT || even == `CMD_HYPOTHETICAL_LOAD_CURRENT ||
        even == `CMD_PACK_TEMPERATURE) begin
      w = 1'b1; // RL10
    end
    if (even == `CMD_PROGRAMMED_CHARGE_MA || even == `CMD_PROGRAMMED_CHARGE_MV ||
        even == `CMD_CHARGE_STAGE_CODE || even >= `CMD_STAGE_TAPER_MA) begin
      w = 1'b0; // RL12
    end
    return w;
  endfunction

  // flash location: low subclass bits above the offset
  assign flash_loc = {b.flash_sel[10:8], b.flash_sel[4:0]}; // RL7

  assign sda_out = l.sda_o;
  assign sda_oe = l.oe;
  assign locked_access_mode = b.locked;
  assign power_mode = b.mode;
  assign charger_enable = b.chg_en;
  assign charger_ma = b.chg_ma;
  assign charger_mv = b.chg_mv;
  assign charge_level_int = b.soc_int;

  // link side: pins synchronised, edges found on the link clock
  always_comb begin
    next_l = l;
    next_l.scl_m = scl_in;
    next_l.scl_s = l.scl_m;
    next_l.scl_d = l.scl_s;
    next_l.sda_m = sda_in;
    next_l.sda_s = l.sda_m;
    next_l.sda_d = l.sda_s;
    next_l.ack_m = b.ack_tgl;
    next_l.ack_s = l.ack_m;
    rise = l.scl_s & ~l.scl_d;
    fall = ~l.scl_s & l.scl_d;
    if (l.scl_s && l.scl_d && l.sda_d && !l.sda_s) begin
      // start or repeated start; pointer survives for the read
      next_l.st = ls_addr;
      next_l.cnt = 3'd0;
      next_l.oe = 1'b0;
    end else if (l.scl_s && l.scl_d && !l.sda_d && l.sda_s) begin
      // stop releases the line
      next_l.st = ls_idle;
      next_l.oe = 1'b0;
    end else begin
      unique case (l.st)
        ls_idle: begin
          next_l.oe = 1'b0;
        end
        ls_addr: begin
          if (rise) begin
            next_l.shift = {l.shift[6:0], l.sda_s};
            next_l.cnt = 3'(l.cnt + 3'd1);
            if (l.cnt == 3'd7) begin
              next_l.st = ls_addr_chk;
            end
          end
        end
        ls_addr_chk: begin
          if (fall) begin
            if (l.shift[7:1] == DEVICE_ADDRESS) begin
              next_l.oe = 1'b1; // address acknowledge
              next_l.rw = l.shift[0];
              next_l.st = ls_ack_addr;
            end else begin
              next_l.st = ls_idle; // not ours, stay off the line
            end
          end
        end
        ls_ack_addr: begin
          if (fall) begin
            next_l.oe = 1'b0;
            next_l.cnt = 3'd0;
            if (l.rw) begin
              // read at the pointer set by the previous transfer
              next_l.req_we = 1'b0; // RL3
              next_l.req_code = l.pointer;
              next_l.req_tgl = ~l.req_tgl;
              next_l.st = ls_fetch;
            end else begin
              next_l.first = 1'b1;
              next_l.st = ls_wbyte;
            end
          end
        end
        ls_fetch: begin
          // drive only while the clock is low, so no false start/stop
          if (l.ack_s == l.req_tgl && !l.scl_s) begin
            next_l.shift = b.rdata;
            next_l.oe = ~b.rdata[7];
            next_l.cnt = 3'd0;
            next_l.st = ls_rbyte;
          end
        end
        ls_rbyte: begin
          if (fall) begin
            next_l.cnt = 3'(l.cnt + 3'd1);
            next_l.shift = {l.shift[6:0], 1'b0};
            if (l.cnt == 3'd7) begin
              next_l.oe = 1'b0;
              next_l.st = ls_rack;
            end else begin
              next_l.oe = ~l.shift[6];
            end
          end
        end
        ls_rack: begin
          if (rise) begin
            if (!l.sda_s) begin
              // host wants more: fetch the following code
              next_l.pointer = 8'(l.pointer + 8'd1);
              next_l.req_we = 1'b0;
              next_l.req_code = 8'(l.pointer + 8'd1);
              next_l.req_tgl = ~l.req_tgl;
              next_l.st = ls_fetch;
            end else begin
              next_l.st = ls_idle;
            end
          end
        end
        ls_wbyte: begin
          if (rise) begin
            next_l.shift = {l.shift[6:0], l.sda_s};
            next_l.cnt = 3'(l.cnt + 3'd1);
            if (l.cnt == 3'd7) begin
              next_l.st = ls_wchk;
            end
          end
        end
        ls_wchk: begin
          if (fall) begin
            next_l.oe = 1'b1;
            next_l.st = ls_wack;
            if (l.first) begin
              // first byte of a write is the command code
              next_l.pointer = l.shift; // RL3
              next_l.first = 1'b0;
            end else begin
              // byte spacing at 400 kHz far exceeds the handshake
              next_l.req_we = 1'b1; // RL5
              next_l.req_code = l.pointer;
              next_l.req_data = l.shift;
              next_l.req_tgl = ~l.req_tgl;
              next_l.pointer = 8'(l.pointer + 8'd1); // RL4
            end
          end
        end
        ls_wack: begin
          if (fall) begin
            next_l.oe = 1'b0;
            next_l.cnt = 3'd0;
            next_l.st = ls_wbyte;
          end
        end
      endcase
    end
  end

  // link state register
  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      l <= '0;
      l.scl_m <= 1'b1;
      l.scl_s <= 1'b1;
      l.scl_d <= 1'b1;
      l.sda_m <= 1'b1;
      l.sda_s <= 1'b1;
      l.sda_d <= 1'b1;
      l.st <= ls_idle;
    end else begin
      l <= next_l;
    end
  end

  // word seen by a read request
  always_comb begin
    pair_code = {l.req_code[7:1], 1'b0};
    rd_word = 16'h0000; // unlisted codes read zero
    if (pair_code == `CMD_FLASH_SELECT) begin
      rd_word = b.flash_sel;
    end else if (pair_code == `CMD_FLASH_DATA) begin
      rd_word = b.locked ? 16'h0000 : {8'h00, flash_mem[flash_loc]}; // RL8
    end else if (pair_listed(pair_code)) begin
      rd_word = reg_mem[l.req_code[6:1]]; // RL6
    end
  end

  // bank side: requests, pair commits, modes, charger, interrupt
  always_comb begin
    next_b = b;
    next_b.req_m = l.req_tgl;
    next_b.req_s = b.req_m;
    next_b.req_d = b.req_s;
    bank_evt = b.req_s != b.req_d;
    pair_val = {l.req_data, b.low_pending}; // RL19
    mem_we = 1'b0;
    mem_idx = l.req_code[6:1];
    mem_wdata = pair_val;
    flash_we = 1'b0;
    if (bank_evt) begin
      next_b.ack_tgl = ~b.ack_tgl; // RL16
      if (!l.req_we) begin
        next_b.rdata = l.req_code[0] ? rd_word[15:8] : rd_word[7:0]; // RL19
      end else if (!l.req_code[0]) begin
        next_b.low_pending = l.req_data; // RL1
      end else if (pair_code == `CMD_FLASH_SELECT || pair_code == `CMD_FLASH_DATA) begin
        if (!b.locked) begin
          // open mode only; locked writes drop silently
          if (pair_code == `CMD_FLASH_SELECT) begin
            next_b.flash_sel = pair_val; // RL7
          end else begin
            flash_we = 1'b1; // RL8
          end
        end
      end else if (pair_listed(pair_code) && pair_writable(pair_code, b.locked)) begin
        mem_we = 1'b1; // RL2
        if (pair_code == `CMD_CONTROL_SUBCOMMAND_PORT) begin
          // subcommand acts when its high byte lands
          unique case (pair_val) // RL17
            `SUB_ENTER_LOCKED: begin
              if (!b.locked) begin
                next_b.locked = 1'b1; // RL18
              end
            end
            `SUB_SET_HIBERNATE: next_b.hib_req = 1'b1;
            `SUB_CLEAR_HIBERNATE: next_b.hib_req = 1'b0;
            `SUB_SET_SNOOZE: next_b.snooze_req = 1'b1;
            `SUB_CLEAR_SNOOZE: next_b.snooze_req = 1'b0;
            `SUB_HALF_CURRENT_ON: next_b.div_half = 1'b1;
            `SUB_HALF_CURRENT_OFF: next_b.div_half = 1'b0;
            `SUB_CHARGER_ON: next_b.chg_en = 1'b1;
            `SUB_CHARGER_OFF: next_b.chg_en = 1'b0;
            default: ; // other subcommands only stored
          endcase
        end
      end
    end
    // power modes follow pack and load events
    unique case (b.mode) // RL14
      pm_normal: begin
        if (load_idle) begin
          next_b.mode = b.hib_req ? pm_hibernate : pm_sleep;
        end
      end
      pm_sleep: begin
        if (!load_idle) begin
          next_b.mode = pm_normal;
        end else if (b.snooze_req) begin
          next_b.mode = pm_deep_snooze;
        end
      end
      pm_deep_snooze: begin
        if (!load_idle || !b.snooze_req) begin
          next_b.mode = pm_normal;
        end
      end
      pm_hibernate: begin
        if (!load_idle || !b.hib_req) begin
          next_b.mode = pm_normal;
        end
      end
      pack_presence_check_mode: begin
        if (pack_present) begin
          next_b.mode = pm_normal;
        end
      end
    endcase
    if (!pack_present) begin
      next_b.mode = pack_presence_check_mode; // RL14
    end
    // charger targets: profile picks the source word
    next_b.chg_ma = multi_step_charging ? reg_mem[CALC_MA_IDX] : reg_mem[PROG_MA_IDX]; // RL15
    if (b.div_half) begin
      next_b.chg_ma = {1'b0, next_b.chg_ma[15:1]};
    end
    next_b.chg_mv = multi_step_charging ? reg_mem[CALC_MV_IDX] : reg_mem[PROG_MV_IDX]; // RL15
    // any change of charge level raises a timed interrupt pulse
    next_b.soc_prev = reg_mem[SOC_IDX];
    if (reg_mem[SOC_IDX] != b.soc_prev) begin
      next_b.soc_cnt = 8'(SOC_PULSE_CYCLES); // RL13
    end else if (b.soc_cnt != 8'd0) begin
      next_b.soc_cnt = 8'(b.soc_cnt - 8'd1);
    end
    next_b.soc_int = next_b.soc_cnt != 8'd0; // RL13
  end

  // bank state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      b <= '0;
      b.locked <= `LOCKED_AT_RESET;
      b.mode <= pm_normal;
    end else begin
      b <= next_b;
    end
  end

  // word store: core updates first, a host commit overrides
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_WORDS; i++) begin
        reg_mem[i] <= `REG_RESET;
      end
    end else begin
      if (gauge_wr && int'(gauge_index) < REG_WORDS) begin
        reg_mem[gauge_index] <= gauge_value;
      end
      if (mem_we) begin
        reg_mem[mem_idx] <= mem_wdata; // RL20
      end
    end
  end

  // parameter store, keeps contents through reset
  always_ff @(posedge clock) begin
    if (flash_we) begin
      flash_mem[flash_loc] <= pair_val[7:0];
    end
  end

  // handshake steps on the bank side
  sequence req_seen_s;
    bank_evt;
  endsequence
  sequence ack_flip_s;
    ##1 (b.ack_tgl != $past(b.ack_tgl));
  endsequence

  req_answer_a: assert property (@(posedge clock) disable iff (rst) req_seen_s |-> ack_flip_s) // RL16
    else $error("request not answered");
  stage_ro_a: assert property (@(posedge clock) disable iff (rst) // RL12
    $changed(reg_mem[STAGE_IDX]) |-> $past(gauge_wr && gauge_index == STAGE_IDX))
    else $error("charge stage changed by host");
  time_left_a: assert property (@(posedge clock) disable iff (rst) // RL9
    ($changed(reg_mem[2]) && $past(b.locked)) |-> $past(gauge_wr && gauge_index == 6'd2))
    else $error("time left written while locked");
  temp_write_a: assert property (@(posedge clock) disable iff (rst) // RL10
    (bank_evt && l.req_we && l.req_code == 8'h07 && !gauge_wr) |=> (reg_mem[3] == $past(pair_val)))
    else $error("temperature write lost");
  read_high_a: assert property (@(posedge clock) disable iff (rst) // RL19
    (bank_evt && !l.req_we && l.req_code == 8'h09) |=> (b.rdata == $past(reg_mem[4][15:8])))
    else $error("odd code did not return high byte");
  lock_cmd_a: assert property (@(posedge clock) disable iff (rst) // RL18
    (mem_we && mem_idx == 6'd0 && mem_wdata == 16'h0020) |=> b.locked ##1 b.locked)
    else $error("lock subcommand ignored");
  soc_pulse_a: assert property (@(posedge clock) disable iff (rst) // RL13
    $changed(reg_mem[SOC_IDX]) |=> charge_level_int [*8])
    else $error("charge interrupt too short");
  presence_a: assert property (@(posedge clock) disable iff (rst) // RL14
    !pack_present |=> (power_mode == pack_presence_check_mode))
    else $error("missing pack not checked");
  charger_a: assert property (@(posedge clock) disable iff (rst) // RL15
    (!multi_step_charging && !b.div_half) |=> (charger_ma == $past(reg_mem[PROG_MA_IDX])))
    else $error("charger current not from programmed word");
  write_ack_a: assert property (@(posedge link_clock) disable iff (rst) // RL3
    (l.st == ls_wchk && fall) |=> (sda_oe && l.st == ls_wack) ##[1:200] !sda_oe)
    else $error("data byte not acknowledged");
endmodule

// ---- test/host_link_model.sv ----
// host processor model: serial bus master that reaches the gauge command port
`timescale 1ns/10ps
module host_link_model #(
  parameter logic [6:0] TARGET = 7'h55 // arbitrary, must match the device instance
) (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  localparam int T_LOW = 1300; // clock low phase
  localparam int T_HIGH = 1200; // 2500 ns period keeps the bus at 400 kHz
  localparam int T_HOLD = 200; // data moves well after the clock fall
  localparam int T_SETUP = 600; // start and stop setup and hold
  localparam int T_BUF = 66000; // bus free time after a stop
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // one bit slot: data changes only while the clock is low, sampled mid-high
  task automatic bit_slot(input logic b, output logic seen);
    #(T_HOLD);
    sda_pull = !b;
    #(T_LOW - T_HOLD);
    scl = 1'b1;
    #(T_HIGH / 2);
    seen = sda;
    #(T_HIGH / 2);
    scl = 1'b0;
  endtask
  // start, or repeated start when the clock is already low
  task automatic start;
    if (scl === 1'b0) begin
      #(T_HOLD);
      sda_pull = 1'b0;
      #(T_LOW - T_HOLD);
      scl = 1'b1;
      #(T_SETUP);
    end
    sda_pull = 1'b1;
    #(T_SETUP);
    scl = 1'b0;
  endtask
  // stop, then leave the bus idle for the free time
  task automatic stop;
    #(T_HOLD);
    sda_pull = 1'b1;
    #(T_LOW - T_HOLD);
    scl = 1'b1;
    #(T_SETUP);
    sda_pull = 1'b0;
    #(T_BUF);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
    bit_slot(1'b1, s);
    ack = !s;
  endtask
  task automatic recv(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(!more, s); // ack keeps the device sending, nack ends
  endtask
  // code transfer then one data byte: single-byte writes only above 100 kHz
  task automatic write_one(input logic [7:0] code, input logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start();
    send({TARGET, 1'b0}, a0);
    send(code, a1);
    send(data, a2);
    ok = a0 & a1 & a2;
  endtask
  // low byte to the even code, then high byte to the odd code
  task automatic write_word(input logic [7:0] code, input logic [15:0] value, output logic ok);
    logic k0, k1;
    write_one(code, value[7:0], k0);
    write_one(code | 8'h01, value[15:8], k1);
    ok = k0 & k1;
  endtask
  // set the code, repeated start, read n bytes
  task automatic read_bytes(input logic [7:0] code, input int n, output logic [7:0] rd [6], output logic ok);
    logic a0, a1, a2;
    start();
    send({TARGET, 1'b0}, a0);
    send(code, a1);
    start();
    send({TARGET, 1'b1}, a2);
    for (int i = 0; i < n; i++) recv(i < n - 1, rd[i]);
    ok = a0 & a1 & a2;
  endtask
endmodule

// ---- test/tb.sv ----
// self-checking bench for the standard command bank
`timescale 1ns/10ps
`include "gauge_bank_regs.svh"
module tb
  import gauge_bank_pkg::*;
;
  logic clock = 1'b0; // bank clock
  logic link_clock = 1'b0; // serial engine clock, free running
  logic rst = 1'b1;
  logic gauge_wr = 1'b0; // core update strobe
  logic [5:0] gauge_index = 6'h00;
  logic [15:0] gauge_value = 16'h0000;
  logic load_idle = 1'b0; // busy except in the sleep step
  logic pack_present = 1'b1;
  logic multi_step_charging = 1'b1;
  logic scl, host_pull, sda_out, sda_oe;
  logic locked_access_mode, charger_enable, charge_level_int;
  logic [15:0] charger_ma;
  logic [15:0] charger_mv;
  power_mode_t power_mode;
  wire logic sda_line = !(host_pull || (sda_oe && !sda_out)); // pull-up when released
  int num_errors = 0;
  int check_count = 0;
  logic [7:0] rd [6];
  logic ok;
  int n;
  always #5 clock = ~clock;
  // offset keeps the two clocks from ever sharing an edge
  initial begin
    #2.3;
    forever #16 link_clock = ~link_clock;
  end
  gauge_standard_command_bank gauge_standard_command_bank_i (
    .clock(clock), .rst(rst), .link_clock(link_clock), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .gauge_wr(gauge_wr), .gauge_index(gauge_index),
    .gauge_value(gauge_value), .load_idle(load_idle), .pack_present(pack_present),
    .multi_step_charging(multi_step_charging), .locked_access_mode(locked_access_mode),
    .power_mode(power_mode), .charger_enable(charger_enable), .charger_ma(charger_ma),
    .charger_mv(charger_mv), .charge_level_int(charge_level_int)
  );
  host_link_model host_link_model_i (.scl(scl), .sda_pull(host_pull), .sda(sda_line));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // sample after the edge's updates have landed
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  // core side update of one word, index is the code halved
  task automatic core_put(input logic [7:0] code, input logic [15:0] v);
    @(posedge clock);
    gauge_wr <= 1'b1;
    gauge_index <= code[6:1];
    gauge_value <= v;
    @(posedge clock);
    gauge_wr <= 1'b0;
  endtask
  // watchdog: the bus session needs about 1.1 ms
  initial begin
    #1_250_000;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    tick();
    check({15'h0, locked_access_mode}, 16'h0000);
    check({15'h0, charge_level_int}, 16'h0000);
    core_put(`CMD_CELL_MILLIVOLTS, 16'h0e74);
    core_put(`CMD_PROGRAMMED_CHARGE_MA, 16'h01f4);
    core_put(`CMD_COMPUTED_CHARGE_MA, 16'h0320);
    core_put(`CMD_PROGRAMMED_CHARGE_MV, 16'h1068);
    core_put(`CMD_COMPUTED_CHARGE_VOLTS, 16'h1036);
    core_put(`CMD_CHARGE_STAGE_CODE, 16'h0005);
    // charge level change raises one fixed-width pulse
    core_put(`CMD_CHARGE_LEVEL_PCT, 16'h0032);
    n = 0;
    while (charge_level_int !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    n = 0;
    while (charge_level_int === 1'b1 && n < 200) begin
      tick();
      n++;
    end
    check(16'(n), 16'h0064);
    // missing pack forces the presence check mode
    @(posedge clock);
    pack_present <= 1'b0;
    repeat (4) tick();
    check({13'h0, power_mode}, {13'h0, pack_presence_check_mode});
    @(posedge clock);
    pack_present <= 1'b1;
    repeat (10) tick();
    // idle load drops the gauge into sleep on its own
    @(posedge clock);
    load_idle <= 1'b1;
    repeat (4) tick();
    check({13'h0, power_mode}, {13'h0, pm_sleep});
    @(posedge clock);
    load_idle <= 1'b0;
    repeat (4) tick();
    check({13'h0, power_mode}, {13'h0, pm_normal});
    // open mode: time left writable, stage code refused at its commit byte
    host_link_model_i.write_word(`CMD_HYPOTHETICAL_LOAD_TIME_LEFT, 16'h1234, ok);
    check({15'h0, ok}, 16'h0001);
    host_link_model_i.write_one(`CMD_CHARGE_STAGE_CODE | 8'h01, 8'hbb, ok);
    check({15'h0, ok}, 16'h0001);
    host_link_model_i.write_word(`CMD_CONTROL_SUBCOMMAND_PORT, `SUB_CHARGER_ON, ok);
    check({15'h0, charger_enable}, 16'h0001);
    check(charger_ma, 16'h0320);
    check(charger_mv, 16'h1036);
    @(posedge clock);
    multi_step_charging <= 1'b0;
    repeat (8) tick();
    check(charger_ma, 16'h01f4);
    check(charger_mv, 16'h1068);
    host_link_model_i.write_word(`CMD_CONTROL_SUBCOMMAND_PORT, `SUB_ENTER_LOCKED, ok);
    check({15'h0, locked_access_mode}, 16'h0001);
    // locked mode: time left refused, temperature still taken
    host_link_model_i.write_one(`CMD_HYPOTHETICAL_LOAD_TIME_LEFT | 8'h01, 8'h56, ok);
    check({15'h0, ok}, 16'h0001);
    host_link_model_i.write_word(`CMD_PACK_TEMPERATURE, 16'h0bb8, ok);
    check({15'h0, ok}, 16'h0001);
    host_link_model_i.read_bytes(`CMD_HYPOTHETICAL_LOAD_TIME_LEFT, 6, rd, ok);
    check({rd[1], rd[0]}, 16'h1234);
    check({rd[3], rd[2]}, 16'h0bb8);
    check({rd[5], rd[4]}, 16'h0e74);
    host_link_model_i.read_bytes(`CMD_CHARGE_STAGE_CODE, 2, rd, ok);
    check({rd[1], rd[0]}, 16'h0005);
    check({15'h0, ok}, 16'h0001);
    host_link_model_i.stop();
    close_out();
  end
endmodule
